/* File: design/sarpr_pkg.sv */
package sarpr_pkg;
    // Conversion timing at a 100 MHz clock
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CONV_TIME_NS    = 610;
    localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int RESTART_NS      = 20;
    localparam int RESTART_CYCLES  = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 8;
    // Host side timing
    localparam int STROBE_LOW_NS   = 20;
    localparam int STROBE_CYCLES   = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUIET_PRE_NS    = 50;
    localparam int QUIET_PRE_CYC   = (QUIET_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUIET_POST_NS   = 40;
    localparam int QUIET_POST_CYC  = (QUIET_POST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_NS          = 150;
    localparam int ACQ_CYCLES      = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WARMUP_CONV     = 3;
    // Result format
    localparam int RES_W           = 16;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] CODE_POS_FS  = 16'h7FFF;
    localparam logic [15:0] CODE_NEG_FS  = 16'h8000;
    localparam logic [7:0]  BYTE_FILL    = 8'hFF;
endpackage : sarpr_pkg

/* File: design/sarpr_bus_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Parallel converter bus between the converter end and the host end
interface sarpr_bus_if;
    logic        convertStartN;
    logic        chipSelectN;
    logic        readN;
    logic        byteSelect;
    logic        busy;
    logic [15:0] resultOutputLines;
    logic        resultOe;
    logic [15:0] busLevel;

    // Wire level: floating lines read as zero in this model
    assign busLevel = resultOe ? resultOutputLines : 16'h0000;

    modport device (
        input  convertStartN,
        input  chipSelectN,
        input  readN,
        input  byteSelect,
        output busy,
        output resultOutputLines,
        output resultOe
    );
    modport host (
        output convertStartN,
        output chipSelectN,
        output readN,
        output byteSelect,
        input  busy,
        input  busLevel
    );
endinterface : sarpr_bus_if
`default_nettype wire

/* File: design/sarpr_device.sv */
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Conversion timed by internal clock, none supplied
// - Each conversion completes in 610 ns
// - Host holds start low 20 ns, select low
// - Start falling edge switches sample to hold
// - Busy high throughout conversion, low at end
// - Sampling restarts on busy or select fall
// - Select must be low when start falls
// - Drive bus only with select and read low
// - Result is 16-bit two's complement word
// - Codes 7FFF, 0000, FFFF, 8000 at extremes
// - Host avoids reads near start falling edge
// - Byte select low: full word, MSB top
// - Byte select high: low byte on upper lines
// - Byte host reads high byte then low
// - Read strobe pulsed or held low per byte
// - Host leaves 150 ns acquisition before start
// - Output latches hold previous completed result
// - Reset aborts, clears latches, resamples after 20 ns
// - Start during conversion with select performs reset
// - Host runs three conversions after power-on
module sarpr_device (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    sarpr_bus_if.device                   bus,
    input  wire logic [sarpr_pkg::RES_W-1:0] sampleCode,
    output logic                          holdMode,
    output logic                          sampling
);
    import sarpr_pkg::*;

    typedef enum logic [1:0] {
        SARPR_RESTART = 2'b00,
        SARPR_IDLE    = 2'b01,
        SARPR_CONVERT = 2'b10
    } sarpr_state_t;

    typedef struct packed {
        logic [1:0]       startSync;
        logic [1:0]       selSync;
        logic [1:0]       readSync;
        logic [1:0]       byteSync;
        logic             startPrev;
        logic             selPrev;
        sarpr_state_t     state;
        logic [CNT_W-1:0] count;
        logic [RES_W-1:0] held;
        logic [RES_W-1:0] result;
        logic             busy;
        logic             hold;
        logic             sampling;
        logic             oe;
        logic [RES_W-1:0] lines;
    } sarpr_dev_t;

    // Values after reset; synchronisers rest at the idle pin levels
    // so that no false strobe edge follows the release of reset
    localparam sarpr_dev_t DEV_RESET = '{
        startSync: 2'b11,
        selSync:   2'b11,
        readSync:  2'b11,
        byteSync:  2'b00,
        startPrev: 1'b1,
        selPrev:   1'b1,
        // Control restarts with the output latches cleared
        state:     SARPR_RESTART,
        count:     '0,
        held:      RESULT_RESET,
        result:    RESULT_RESET,
        busy:      1'b0,
        hold:      1'b0,
        sampling:  1'b0,
        oe:        1'b0,
        lines:     RESULT_RESET
    };

    sarpr_dev_t st_reg;
    sarpr_dev_t st_next;

    // Second-stage pin levels and their falling edges
    logic startN;
    logic selN;
    logic startFall;
    logic selFall;

    // Pins pass two flops; edges use the second stage only
    assign startN    = st_reg.startSync[1];
    assign selN      = st_reg.selSync[1];
    assign startFall = st_reg.startPrev && !startN;
    assign selFall   = st_reg.selPrev && !selN;

    // Next state of the converter control
    always_comb
    begin
        st_next = st_reg;
        // Pins shift into their two-stage synchronisers every cycle
        st_next.startSync = {st_reg.startSync[0], bus.convertStartN};
        st_next.selSync   = {st_reg.selSync[0], bus.chipSelectN};
        st_next.readSync  = {st_reg.readSync[0], bus.readN};
        st_next.byteSync  = {st_reg.byteSync[0], bus.byteSelect};
        st_next.startPrev = startN;
        st_next.selPrev   = selN;
        case (st_reg.state)
            SARPR_RESTART:
            begin
                // Resampling begins a fixed delay after reset release
                if (st_reg.count >= CNT_W'(RESTART_CYCLES - 1))
                begin
                    st_next.state    = SARPR_IDLE;
                    st_next.sampling = 1'b1;
                    st_next.count    = '0;
                end
                else
                begin
                    st_next.count = st_reg.count + CNT_W'(1);
                end
            end
            SARPR_IDLE:
            begin
                // Select low when start falls begins a conversion
                if (startFall && !selN)
                begin
                    st_next.state    = SARPR_CONVERT;
                    st_next.hold     = 1'b1;
                    st_next.sampling = 1'b0;
                    st_next.held     = sampleCode;
                    st_next.busy     = 1'b1;
                    st_next.count    = '0;
                end
                else if (selFall && !st_reg.sampling)
                begin
                    // A deselected finish waits for select to fall before sampling
                    st_next.sampling = 1'b1;
                    st_next.hold     = 1'b0;
                end
            end
            SARPR_CONVERT:
            begin
                // Internal clock counts the conversion; a start with select low while busy aborts it
                if (startFall && !selN)
                begin
                    // Self-clearing reset: same effect as the reset pin
                    st_next.state    = SARPR_RESTART;
                    st_next.busy     = 1'b0;
                    st_next.hold     = 1'b0;
                    st_next.result   = RESULT_RESET;
                    st_next.count    = '0;
                end
                else if (st_reg.count >= CNT_W'(CONV_CYCLES - 1))
                begin
                    st_next.state  = SARPR_IDLE;
                    st_next.busy   = 1'b0;
                    st_next.result = st_reg.held;
                    st_next.count  = '0;
                    // With select low sampling follows busy's fall
                    if (!selN)
                    begin
                        st_next.sampling = 1'b1;
                        st_next.hold     = 1'b0;
                    end
                end
                else
                begin
                    st_next.count = st_reg.count + CNT_W'(1);
                end
            end
            default:
            begin
                // Unused code: recover through the restart path
                st_next.state = SARPR_RESTART;
            end
        endcase

        // Bus driven only with both strobes low; byte mode moves low byte up
        st_next.oe = !selN && !st_reg.readSync[1];
        if (st_reg.byteSync[1])
        begin
            st_next.lines = {st_next.result[7:0], BYTE_FILL};
        end
        else
        begin
            st_next.lines = st_next.result;
        end
    end

    // State register; reset aborts and clears the latches
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= DEV_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Every output comes straight from the state register
    assign bus.busy              = st_reg.busy;
    assign bus.resultOe          = st_reg.oe;
    assign bus.resultOutputLines = st_reg.lines;
    assign holdMode              = st_reg.hold;
    assign sampling              = st_reg.sampling;
endmodule : sarpr_device
`default_nettype wire

/* File: design/sarpr_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Host end: starts conversions and reads the result on word or byte bus
module sarpr_host (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    sarpr_bus_if.host                     bus,
    input  wire logic                     startReq,
    input  wire logic                     byteMode,
    output logic [sarpr_pkg::RES_W-1:0]   resultWord,
    output logic                          resultValid,
    output logic                          hostReady,
    output logic                          warmedUp
);
    import sarpr_pkg::*;

    typedef enum logic [2:0] {
        SARPH_ACQ    = 3'b000,
        SARPH_IDLE   = 3'b001,
        SARPH_STROBE = 3'b010,
        SARPH_WAIT   = 3'b011,
        SARPH_QUIET  = 3'b100,
        SARPH_READHI = 3'b101,
        SARPH_READLO = 3'b110
    } sarpr_hstate_t;

    typedef struct packed {
        logic [1:0]       busySync;
        logic             busyPrev;
        logic [RES_W-1:0] busSync0;
        logic [RES_W-1:0] busSync1;
        sarpr_hstate_t    state;
        logic [CNT_W-1:0] count;
        logic [1:0]       convDone;
        logic             startN;
        logic             selN;
        logic             readN;
        logic             byteSel;
        logic [RES_W-1:0] word;
        logic             valid;
        logic             ready;
        logic             warm;
    } sarpr_host_t;

    sarpr_host_t st_reg;
    sarpr_host_t st_next;
    logic        busyFall;

    assign busyFall = st_reg.busyPrev && !st_reg.busySync[1];

    // Host sequencing; read data sampled after two flops
    always_comb
    begin
        st_next = st_reg;
        st_next.busySync = {st_reg.busySync[0], bus.busy};
        st_next.busyPrev = st_reg.busySync[1];
        st_next.busSync0 = bus.busLevel;
        st_next.busSync1 = st_reg.busSync0;
        st_next.valid    = 1'b0;
        st_next.count    = st_reg.count + CNT_W'(1);
        case (st_reg.state)
            SARPH_ACQ:
            begin
                // Acquisition time plus read quiet zone before next start
                if (st_reg.count >= CNT_W'(ACQ_CYCLES + QUIET_PRE_CYC))
                begin
                    st_next.state = SARPH_IDLE;
                    st_next.ready = 1'b1;
                end
            end
            SARPH_IDLE:
            begin
                if (startReq)
                begin
                    st_next.state  = SARPH_STROBE;
                    st_next.selN   = 1'b0;
                    st_next.startN = 1'b0;
                    st_next.ready  = 1'b0;
                    st_next.count  = '0;
                end
            end
            SARPH_STROBE:
            begin
                if (st_reg.count >= CNT_W'(STROBE_CYCLES))
                begin
                    st_next.startN = 1'b1;
                    st_next.state  = SARPH_WAIT;
                end
            end
            SARPH_WAIT:
            begin
                // Busy fall marks a new result
                if (busyFall)
                begin
                    st_next.state = SARPH_QUIET;
                    st_next.readN = 1'b0;
                    st_next.byteSel = 1'b0;
                    st_next.count = '0;
                end
            end
            SARPH_QUIET:
            begin
                // Read data needs two device flops, its register and two host flops
                if (st_reg.count >= CNT_W'(QUIET_POST_CYC + 1))
                begin
                    st_next.state = SARPH_READHI;
                    st_next.word = st_reg.busSync1;
                    if (byteMode)
                    begin
                        st_next.byteSel = 1'b1;
                        st_next.count = '0;
                    end
                end
            end
            SARPH_READHI:
            begin
                if (!byteMode)
                begin
                    st_next.state = SARPH_READLO;
                end
                else if (st_reg.count >= CNT_W'(QUIET_POST_CYC + 1))
                begin
                    st_next.word  = {st_reg.word[15:8], st_reg.busSync1[15:8]};
                    st_next.state = SARPH_READLO;
                end
            end
            SARPH_READLO:
            begin
                st_next.readN   = 1'b1;
                st_next.selN    = 1'b1;
                st_next.byteSel = 1'b0;
                st_next.count   = '0;
                st_next.state   = SARPH_ACQ;
                if (st_reg.convDone >= 2'(WARMUP_CONV - 1))
                begin
                    st_next.warm  = 1'b1;
                    st_next.valid = 1'b1;
                end
                else
                begin
                    st_next.convDone = st_reg.convDone + 2'(1);
                end
            end
            default:
            begin
                st_next.state = SARPH_ACQ;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '{busySync: 2'b00, busyPrev: 1'b0, busSync0: '0, busSync1: '0,
                        state: SARPH_ACQ, count: '0, convDone: 2'b00, startN: 1'b1,
                        selN: 1'b1, readN: 1'b1, byteSel: 1'b0, word: RESULT_RESET,
                        valid: 1'b0, ready: 1'b0, warm: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign bus.convertStartN = st_reg.startN;
    assign bus.chipSelectN   = st_reg.selN;
    assign bus.readN         = st_reg.readN;
    assign bus.byteSelect    = st_reg.byteSel;
    assign resultWord        = st_reg.word;
    assign resultValid       = st_reg.valid;
    assign hostReady         = st_reg.ready;
    assign warmedUp          = st_reg.warm;
endmodule : sarpr_host
`default_nettype wire

/* File: test/sarpr_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// Watches the converter bus where both ends are design code
module sarpr_checker
    import sarpr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        convertStartN,
    input wire logic        chipSelectN,
    input wire logic        readN,
    input wire logic        byteSelect,
    input wire logic        busy,
    input wire logic [15:0] resultOutputLines,
    input wire logic        resultOe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic [7:0] busyCnt_reg;
    logic [7:0] rdHigh_reg;
    logic [7:0] off_reg;
    logic [7:0] gap_reg;
    // Run lengths; idle ones saturate at 64 so they never wrap
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busyCnt_reg <= 8'h00;
            rdHigh_reg  <= 8'h00;
            off_reg     <= 8'h00;
            gap_reg     <= 8'h00;
        end
        else
        begin
            busyCnt_reg <= busy ? busyCnt_reg + 8'h01 : 8'h00;
            rdHigh_reg  <= readN ? rdHigh_reg + {7'h00, rdHigh_reg < 8'h40} : 8'h00;
            off_reg     <= (readN | chipSelectN) ? off_reg + {7'h00, off_reg < 8'h40} : 8'h00;
            gap_reg     <= $fell(busy) ? 8'h00 : gap_reg + {7'h00, gap_reg < 8'h40};
        end
    end
    // Bus pins lag the strobes by the two synchroniser stages and a register
    a_oe_needs_select: assert property (resultOe |-> !$past(chipSelectN, 3) && !$past(readN, 3))
        else $error("output enabled without select and read");
    a_bus_float: assert property (off_reg >= 8'h04 |-> !resultOe)
        else $error("bus driven while deselected");
    a_byte_fill: assert property (resultOe && byteSelect && $past(byteSelect, 3)
        && $past(byteSelect, 4) |-> resultOutputLines[7:0] == BYTE_FILL)
        else $error("lower lines not all ones in byte mode");
    a_busy_rises: assert property ($fell(convertStartN) && !chipSelectN && !busy
        |-> ##[2:4] busy)
        else $error("busy did not follow start");
    a_busy_length: assert property ($fell(busy) |-> busyCnt_reg == 8'(CONV_CYCLES))
        else $error("conversion length wrong");
    a_strobe_width: assert property ($fell(convertStartN)
        |-> (!convertStartN && !chipSelectN) [*2])
        else $error("start strobe too short or select high");
    a_quiet_before: assert property ($fell(convertStartN)
        |-> rdHigh_reg >= 8'(QUIET_PRE_CYC))
        else $error("read too close before start");
    a_quiet_after: assert property ($fell(convertStartN) |-> readN [*4])
        else $error("read too close after start");
    a_acquire_gap: assert property ($fell(convertStartN) |-> gap_reg >= 8'(ACQ_CYCLES))
        else $error("acquisition time too short");
endmodule : sarpr_checker
`default_nettype wire

/* File: test/sar_adc_parallel_readout_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_parallel_readout_tb;
    import sarpr_pkg::*;
    logic        clk;
    logic        rstn;
    logic        startReq;
    logic        byteMode;
    logic [15:0] sampleCode;
    logic [15:0] sampleCode2;
    logic        holdMode2;
    logic        sampling2;
    logic [15:0] resultWord;
    logic        resultValid;
    logic        hostReady;
    logic        warmedUp;
    int          n_fail;
    int          checks;
    logic [15:0] codes [5] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000, 16'hA5C3};
    sarpr_bus_if bus ();
    sarpr_bus_if bus2 ();
    sarpr_device sarpr_device_i (.clk(clk), .rstn(rstn), .bus(bus), .sampleCode(sampleCode),
        .holdMode(), .sampling());
    sarpr_host sarpr_host_i (.clk(clk), .rstn(rstn), .bus(bus), .startReq(startReq),
        .byteMode(byteMode), .resultWord(resultWord), .resultValid(resultValid),
        .hostReady(hostReady), .warmedUp(warmedUp));
    // Second device faces the bench, which breaks host rules on purpose
    sarpr_device sarpr_device_i2 (.clk(clk), .rstn(rstn), .bus(bus2),
        .sampleCode(sampleCode2), .holdMode(holdMode2), .sampling(sampling2));
    sarpr_checker sarpr_checker_i (.clk(clk), .rstn(rstn), .convertStartN(bus.convertStartN),
        .chipSelectN(bus.chipSelectN), .readN(bus.readN), .byteSelect(bus.byteSelect),
        .busy(bus.busy), .resultOutputLines(bus.resultOutputLines), .resultOe(bus.resultOe));
    // Clock
    always #5 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_up(input string what);
        check(what, 16'h0000, 16'h0001);
        stop_test();
    endtask : give_up
    // Pulse the host request once it is idle
    task automatic start_host();
        int i;
        for (i = 0; i < 100 && hostReady !== 1'b1; i++)
            @(negedge clk);
        if (hostReady !== 1'b1)
            give_up("host ready");
        startReq = 1'b1;
        @(negedge clk);
        startReq = 1'b0;
    endtask : start_host
    // One conversion and readout, judged on the bus wire and at the host
    task automatic conv(input logic [15:0] code, input logic bm, input logic expValid);
        int i;
        int busyCnt;
        logic gotValid;
        logic seenBs;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [15:0] word;
        busyCnt = 0;
        gotValid = 1'b0;
        seenBs = 1'b0;
        sampleCode = code;
        byteMode = bm;
        start_host();
        for (i = 0; i < 400; i++)
        begin
            @(negedge clk);
            busyCnt += int'(bus.busy === 1'b1);
            if (resultValid === 1'b1)
            begin
                gotValid = 1'b1;
                word = resultWord;
            end
            if (bus.resultOe === 1'b1 && bus.byteSelect === 1'b0 && !seenBs)
                w0 = bus.busLevel;
            if (bus.resultOe === 1'b1 && bus.byteSelect === 1'b1)
            begin
                seenBs = 1'b1;
                w1 = bus.busLevel;
            end
            if (busyCnt > 0 && hostReady === 1'b1)
                break;
        end
        if (i == 400)
            give_up("conversion end");
        check("busy cycles", 16'(busyCnt), 16'(CONV_CYCLES));
        check("result valid", {15'h0000, gotValid}, {15'h0000, expValid});
        check("warmed up", {15'h0000, warmedUp}, {15'h0000, expValid});
        check("bus idle", {15'h0000, bus.resultOe}, 16'h0000);
        if (expValid)
        begin
            check("result word", word, code);
            if (bm)
            begin
                check("high byte", {8'h00, w0[15:8]}, {8'h00, code[15:8]});
                check("low byte", w1, {code[7:0], BYTE_FILL});
            end
            else
                check("word lines", w0, code);
        end
    endtask : conv
    task automatic warm_up(input logic bm);
        conv(16'h1234, bm, 1'b0);
        conv(16'h1234, bm, 1'b0);
        conv(16'h0F0F, bm, 1'b1);
    endtask : warm_up
    // Reset in mid conversion
    task automatic mid_reset();
        sampleCode = 16'h3C5A;
        start_host();
        repeat (20) @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        check("busy in reset", {15'h0000, bus.busy}, 16'h0000);
        check("lines in reset", bus.resultOutputLines, RESULT_RESET);
        rstn = 1'b1;
    endtask : mid_reset
    task automatic wait_busy2(input logic lvl);
        int i;
        for (i = 0; i < 200 && bus2.busy !== lvl; i++)
            @(negedge clk);
        if (bus2.busy !== lvl)
            give_up("second busy");
    endtask : wait_busy2
    task automatic pulse_start2();
        bus2.convertStartN = 1'b0;
        repeat (3) @(negedge clk);
        bus2.convertStartN = 1'b1;
    endtask : pulse_start2
    // Second device: conversion, read back, ignored start, then a start during conversion
    task automatic fault_bench();
        sampleCode2 = 16'hA5C3;
        bus2.chipSelectN = 1'b0;
        pulse_start2();
        wait_busy2(1'b1);
        check("hold mode", {15'h0000, holdMode2}, 16'h0001);
        wait_busy2(1'b0);
        repeat (2) @(negedge clk);
        check("sampling", {15'h0000, sampling2}, 16'h0001);
        bus2.readN = 1'b0;
        repeat (4) @(negedge clk);
        check("second lines", bus2.busLevel, 16'hA5C3);
        bus2.readN = 1'b1;
        bus2.chipSelectN = 1'b1;
        repeat (4) @(negedge clk);
        check("second float", {15'h0000, bus2.resultOe}, 16'h0000);
        pulse_start2();
        repeat (8) @(negedge clk);
        check("start deselected", {15'h0000, bus2.busy}, 16'h0000);
        bus2.chipSelectN = 1'b0;
        repeat (20) @(negedge clk);
        pulse_start2();
        wait_busy2(1'b1);
        repeat (10) @(negedge clk);
        pulse_start2();
        repeat (4) @(negedge clk);
        check("self reset busy", {15'h0000, bus2.busy}, 16'h0000);
        check("self reset lines", bus2.resultOutputLines, RESULT_RESET);
        repeat (4) @(negedge clk);
        check("restart sampling", {15'h0000, sampling2}, 16'h0001);
    endtask : fault_bench
    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        startReq = 1'b0;
        byteMode = 1'b0;
        sampleCode = 16'h0000;
        sampleCode2 = 16'h0000;
        bus2.convertStartN = 1'b1;
        bus2.chipSelectN = 1'b1;
        bus2.readN = 1'b1;
        bus2.byteSelect = 1'b0;
        n_fail = 0;
        checks = 0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        warm_up(1'b0);
        foreach (codes[k])
            conv(codes[k], 1'b0, 1'b1);
        foreach (codes[k])
            conv(codes[k], 1'b1, 1'b1);
        mid_reset();
        warm_up(1'b1);
        fault_bench();
        stop_test();
    end
endmodule : sar_adc_parallel_readout_tb
`default_nettype wire
